// *** hw/opfu_regs.svh ***
`ifndef OPFU_REGS_SVH
`define OPFU_REGS_SVH

// Word and memory geometry
`define OPFU_W          32
`define OPFU_MEM_WORDS  64

// Saturation bounds
`define OPFU_SAT_MAX    32'h7fffffff
`define OPFU_SAT_MIN    32'h80000000

// Flag bit positions and count
`define OPFU_F_CY       0
`define OPFU_F_OV       1
`define OPFU_F_S        2
`define OPFU_F_Z        3
`define OPFU_F_SAT      4
`define OPFU_NFLAGS     5

// Divider step count
`define OPFU_DIV_STEPS  6'h20

// Latency in cycles, accept to answer
`define OPFU_LAT_ALU    8'h02
`define OPFU_LAT_MEM    8'h03

// Reset values
`define OPFU_RST_FLAGS  5'h00
`define OPFU_RST_WORD   32'h00000000

`endif

// *** hw/opfu_pkg.sv ***
package opfu_pkg;

	// Primitive operations
	typedef enum logic [3:0] {
		OP_SEXT, OP_ZEXT, OP_SATADD, OP_SATSUB, OP_SHL, OP_SHR, OP_SAR,
		OP_DIV, OP_LOAD, OP_STORE, OP_BITRD, OP_BITWR, OP_COND
	} opfu_op_e;

	// Access and operand sizes
	typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} opfu_size_e;

	// Per-flag update policy
	typedef enum logic [1:0] {POL_KEEP, POL_CLR, POL_RES, POL_RESTORE} opfu_pol_e;

	// Flag word, carry in bit 0
	typedef struct packed {
		logic sat;
		logic z;
		logic s;
		logic ov;
		logic cy;
	} opfu_flags_s;

	typedef logic [2:0] opfu_bitsel_t;
	typedef logic [3:0] opfu_cond_t;

	// Widen a short value to a word, by sign or by zeros
	function automatic logic [31:0] opfu_extend(logic [31:0] v, opfu_size_e sz, logic sgn);
		logic [31:0] r;
		r = v;
		case (sz)
			SZ_BYTE: r = {{24{sgn & v[7]}}, v[7:0]};
			SZ_HALF: r = {{16{sgn & v[15]}}, v[15:0]};
			default: r = v;
		endcase
		return r;
	endfunction

	// Condition test; top code bit inverts the base test, except code 4'hd, which tests sat
	function automatic logic opfu_cond_ok(opfu_cond_t cc, opfu_flags_s f);
		logic b;
		b = 1'b0;
		case (cc[2:0])
			3'h0: b = f.ov;
			3'h1: b = f.cy;
			3'h2: b = f.z;
			3'h3: b = f.cy | f.z;
			3'h4: b = f.s;
			3'h6: b = f.s ^ f.ov;
			3'h7: b = (f.s ^ f.ov) | f.z;
			default: b = 1'b1;
		endcase
		if (cc == 4'h5)
			return 1'b1;
		if (cc == 4'hd)
			return f.sat;
		return cc[3] ? ~b : b;
	endfunction

endpackage

// *** hw/opfu_sub_if.sv ***
`timescale 1ns/1ps
interface opfu_sub_if;
	// Memory port
	logic                   mem_req;
	logic                   mem_we;
	logic                   mem_bit;
	logic [7:0]             mem_addr;
	opfu_pkg::opfu_size_e   mem_size;
	logic [2:0]             mem_bsel;
	logic [31:0]            mem_wdata;
	logic [31:0]            mem_rdata;
	logic                   mem_ack;
	// Divider port
	logic                   div_start;
	logic [31:0]            div_a;
	logic [31:0]            div_b;
	logic                   div_busy;
	logic                   div_done;
	logic [31:0]            div_quo;
	logic [31:0]            div_rem;

	modport core (output mem_req, mem_we, mem_bit, mem_addr, mem_size, mem_bsel, mem_wdata,
		input mem_rdata, mem_ack, output div_start, div_a, div_b,
		input div_busy, div_done, div_quo, div_rem);
	modport mem (input mem_req, mem_we, mem_bit, mem_addr, mem_size, mem_bsel, mem_wdata,
		output mem_rdata, mem_ack);
	modport div (input div_start, div_a, div_b, output div_busy, div_done, div_quo, div_rem);
endinterface

// *** hw/opfu_mem.sv ***
`timescale 1ns/1ps
`include "opfu_regs.svh"
module opfu_mem import opfu_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Access port
	opfu_sub_if.mem  m
);
	logic [31:0] ram [`OPFU_MEM_WORDS];  // Word storage, byte lanes inside
	logic [5:0]  widx;                   // Word index
	logic [4:0]  lsb;                    // Low bit of addressed byte
	logic [4:0]  bpos;                   // Selected bit within word
	logic [31:0] rd_word;                // Addressed word as stored
	logic [31:0] bmask;                  // One-hot mask of selected bit
	logic [31:0] next_word;              // Word after the write
	logic [31:0] next_rdata;
	logic        next_ack;

	assign widx    = m.mem_addr[7:2];
	assign lsb     = {m.mem_addr[1:0], 3'h0};
	assign bpos    = lsb | {2'h0, m.mem_bsel};
	assign rd_word = ram[widx];
	assign bmask   = 32'h00000001 << bpos;

	// Read data and merged write word
	always_comb begin
		next_rdata = m.mem_rdata;
		next_ack   = m.mem_req;
		next_word  = rd_word;
		if (m.mem_req && !m.mem_we) begin
			if (m.mem_bit) begin
				next_rdata = {31'h0, |(rd_word & bmask)};
			end else begin
				case (m.mem_size)
					SZ_BYTE: next_rdata = (rd_word >> lsb) & 32'h000000ff;
					SZ_HALF: next_rdata = (rd_word >> {m.mem_addr[1], 4'h0}) & 32'h0000ffff;
					default: next_rdata = rd_word;
				endcase
			end
		end
		// Only the addressed lanes or bit change
		if (m.mem_bit) begin
			next_word = m.mem_wdata[0] ? (rd_word | bmask) : (rd_word & ~bmask);
		end else begin
			case (m.mem_size)
				SZ_BYTE: next_word[lsb +: 8] = m.mem_wdata[7:0];
				SZ_HALF: next_word[{m.mem_addr[1], 4'h0} +: 16] = m.mem_wdata[15:0];
				default: next_word = m.mem_wdata;
			endcase
		end
	end

	// Storage has no reset; contents are undefined until written
	always_ff @(posedge clock) begin
		if (m.mem_req && m.mem_we)
			ram[widx] <= next_word;
	end

	// Answer registers
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			m.mem_rdata <= `OPFU_RST_WORD;
			m.mem_ack   <= 1'b0;
		end else begin
			m.mem_rdata <= next_rdata;
			m.mem_ack   <= next_ack;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	a_mem_ack_next: assert property (m.mem_req |=> m.mem_ack)
		else $error("memory answer not one cycle after request");
	a_byte_keeps_rest: assert property (
		(m.mem_req && m.mem_we && !m.mem_bit && m.mem_size == SZ_BYTE && lsb == 5'h10)
		|=> ram[$past(widx)][15:0] == $past(rd_word[15:0])
		&& ram[$past(widx)][31:24] == $past(rd_word[31:24]))
		else $error("byte store disturbed other lanes");
	a_bit_read_val: assert property (
		(m.mem_req && !m.mem_we && m.mem_bit)
		|=> m.mem_rdata == {31'h0, $past(|(rd_word & bmask))})
		else $error("bit read returned wrong value");
	a_bit_write_one: assert property (
		(m.mem_req && m.mem_we && m.mem_bit)
		|=> ((ram[$past(widx)] & ~$past(bmask)) == ($past(rd_word) & ~$past(bmask)))
		&& (|(ram[$past(widx)] & $past(bmask)) == $past(m.mem_wdata[0])))
		else $error("bit write changed more than the selected bit");
endmodule // opfu_mem

// *** hw/opfu_div.sv ***
`timescale 1ns/1ps
`include "opfu_regs.svh"
module opfu_div import opfu_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Divide port
	opfu_sub_if.div  d
);
	logic [31:0] dvs, next_dvs;   // Divisor held for all steps
	logic [31:0] quo, next_quo;   // Shifts in quotient bits
	logic [31:0] rem, next_rem;   // Partial remainder
	logic [5:0]  cnt, next_cnt;   // Steps taken
	logic        busy, next_busy;
	logic        done, next_done;
	logic [32:0] shl_rem;         // Remainder shifted, one bit wider
	logic [32:0] trial;           // Trial subtraction

	assign shl_rem = {rem, quo[31]};
	assign trial   = shl_rem - {1'b0, dvs};

	// One restoring step per cycle; zero divisor gives all ones
	always_comb begin
		next_dvs  = dvs;
		next_quo  = quo;
		next_rem  = rem;
		next_cnt  = cnt;
		next_busy = busy;
		next_done = 1'b0;
		if (d.div_start && !busy) begin
			next_dvs  = d.div_b;
			next_quo  = d.div_a;
			next_rem  = 32'h0;
			next_cnt  = 6'h0;
			next_busy = 1'b1;
		end else if (busy) begin
			next_rem = trial[32] ? shl_rem[31:0] : trial[31:0];
			next_quo = {quo[30:0], ~trial[32]};
			next_cnt = cnt + 6'h1;
			if (next_cnt == `OPFU_DIV_STEPS) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			dvs  <= `OPFU_RST_WORD;
			quo  <= `OPFU_RST_WORD;
			rem  <= `OPFU_RST_WORD;
			cnt  <= 6'h0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			dvs  <= next_dvs;
			quo  <= next_quo;
			rem  <= next_rem;
			cnt  <= next_cnt;
			busy <= next_busy;
			done <= next_done;
		end
	end

	assign d.div_busy = busy;
	assign d.div_done = done;
	assign d.div_quo  = quo;
	assign d.div_rem  = rem;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence s_div_go;
		d.div_start && !busy;
	endsequence
	a_div_length: assert property (s_div_go |-> ##33 done)
		else $error("divide did not finish after 32 steps");
	a_div_identity: assert property (
		(done && dvs != 32'h0) |-> (64'(quo) * 64'(dvs) + 64'(rem)) == 64'($past(quo, 32))
		&& rem < dvs)
		else $error("quotient and remainder inconsistent");
endmodule // opfu_div

// *** hw/opfu_top.sv ***
`timescale 1ns/1ps
`include "opfu_regs.svh"
// Function
// - Sign extension copies top bit upward
// - Zero extension fills upper bits with zeros
// - Saturation clamps to word signed range
// - Load reads byte, halfword or word
// - Store writes exactly the requested size
// - Bit read returns selected bit
// - Each flag keeps, clears or follows result
// - Restore policy reloads saved flags
// - Logical shifts fill zeros, arithmetic fills sign
// - Division also yields a separate remainder
// - Three-bit field selects bit in byte
// - Four-bit field selects tested condition
// - Latency counts cycles until result usable
module opfu_top import opfu_pkg::*; (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         nrst,
	// Request
	input  wire logic         in_valid,
	output wire logic         in_ready,
	input  wire opfu_op_e     in_op,
	input  wire logic [31:0]  in_a,
	input  wire logic [31:0]  in_b,
	input  wire opfu_size_e   in_size,
	input  wire logic         in_sgn,
	input  wire opfu_bitsel_t in_bit,
	input  wire opfu_cond_t   in_cond,
	input  wire logic [9:0]   in_pol,
	input  wire opfu_flags_s  in_saved,
	// Answer
	output wire logic         out_valid,
	output wire logic [31:0]  out_result,
	output wire logic [31:0]  out_rem,
	output wire opfu_flags_s  out_flags,
	output wire logic [7:0]   out_latency
);
	typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_MWAIT, ST_DIV, ST_DONE} opfu_state_e;

	opfu_sub_if sub ();  // Links to memory and divider

	// Sequencer state
	opfu_state_e  state, next_state;
	logic [7:0]   lat_cnt, next_lat_cnt;   // Cycles since accept

	// Request held for the whole operation
	opfu_op_e     op_q, next_op;
	logic [31:0]  opa_q, next_opa;
	logic [31:0]  opb_q, next_opb;
	opfu_size_e   size_q, next_size;
	logic         sgn_q, next_sgn;
	opfu_bitsel_t bit_q, next_bit;
	opfu_cond_t   cond_q, next_cond;
	logic [9:0]   pol_q, next_pol;
	opfu_flags_s  saved_q, next_saved;

	// Answer registers
	logic [31:0]  result, next_result;
	logic [31:0]  rem, next_rem;
	opfu_flags_s  flags, next_flags;
	logic [7:0]   latency, next_latency;

	// Final value of this cycle, if any
	logic         fin_en;
	logic [31:0]  fin_res;
	logic [31:0]  fin_rem;
	opfu_flags_s  fin_f;       // Flags as the result would set them

	// Arithmetic intermediates
	logic [32:0]  wide_sum;    // Signed, one bit wider than a word
	logic [32:0]  uns_sum;     // Unsigned carry path
	logic [32:0]  sh_l;        // Carry out above the word
	logic [32:0]  sh_r;        // Carry out below the word
	logic [32:0]  sh_a;
	logic         sat_hi;
	logic         sat_lo;
	logic         accept;

	assign accept = in_valid && (state == ST_IDLE);

	// Wide sum keeps the overflow visible before clamping
	always_comb begin
		if (op_q == OP_SATSUB) begin
			wide_sum = {opa_q[31], opa_q} - {opb_q[31], opb_q};
			uns_sum  = {1'b0, opa_q} - {1'b0, opb_q};
		end else begin
			wide_sum = {opa_q[31], opa_q} + {opb_q[31], opb_q};
			uns_sum  = {1'b0, opa_q} + {1'b0, opb_q};
		end
	end
	assign sat_hi = !wide_sum[32] && wide_sum[31];
	assign sat_lo = wide_sum[32] && !wide_sum[31];

	// Shifter; the extra bit catches the last bit shifted out
	assign sh_l = {1'b0, opa_q} << opb_q[4:0];
	assign sh_r = {opa_q, 1'b0} >> opb_q[4:0];
	assign sh_a = 33'($signed({opa_q, 1'b0}) >>> opb_q[4:0]);

	// Final result and the flags it implies
	always_comb begin
		fin_en  = 1'b0;
		fin_res = result;
		fin_rem = rem;
		fin_f   = flags;
		case (state)
			ST_EXEC: begin
				fin_en   = 1'b1;
				fin_f.ov = 1'b0;
				fin_f.cy = 1'b0;
				case (op_q)
					OP_SEXT:  fin_res = opfu_extend(opa_q, size_q, 1'b1);
					OP_ZEXT:  fin_res = opfu_extend(opa_q, size_q, 1'b0);
					OP_SATADD, OP_SATSUB: begin
						fin_res   = sat_hi ? `OPFU_SAT_MAX :
							sat_lo ? `OPFU_SAT_MIN : wide_sum[31:0];
						fin_f.ov  = sat_hi | sat_lo;
						fin_f.cy  = uns_sum[32];
						fin_f.sat = sat_hi | sat_lo;
					end
					OP_SHL: begin
						fin_res  = sh_l[31:0];
						fin_f.cy = sh_l[32];
					end
					OP_SHR: begin
						fin_res  = sh_r[32:1];
						fin_f.cy = sh_r[0];
					end
					OP_SAR: begin
						fin_res  = sh_a[32:1];
						fin_f.cy = sh_a[0];
					end
					OP_COND:  fin_res = {31'h0, opfu_cond_ok(cond_q, flags)};
					// Memory and divide finish later
					default:  fin_en = 1'b0;
				endcase
				fin_f.s = fin_res[31];
				fin_f.z = (fin_res == 32'h0);
				if (op_q == OP_COND)
					fin_f = flags;
			end
			ST_MWAIT: begin
				fin_en  = sub.mem_ack;
				// Bit read reports the bit's inverse in zero; bit write reports the inverse of the held read data
				if (op_q == OP_LOAD)
					fin_res = opfu_extend(sub.mem_rdata, size_q, sgn_q);
				else if (op_q == OP_BITRD || op_q == OP_BITWR)
					fin_res = sub.mem_rdata;
				fin_f.s = fin_res[31];
				fin_f.z = (op_q == OP_BITRD || op_q == OP_BITWR) ?
					~sub.mem_rdata[0] : (fin_res == 32'h0);
			end
			ST_DIV: begin
				fin_en   = sub.div_done;
				fin_res  = sub.div_quo;
				fin_rem  = sub.div_rem;
				fin_f.ov = (opb_q == 32'h0);
				fin_f.s  = sub.div_quo[31];
				fin_f.z  = (sub.div_quo == 32'h0);
			end
			default: fin_en = 1'b0;
		endcase
	end

	// Memory and divider requests, one cycle each from execute
	always_comb begin
		sub.mem_req   = (state == ST_EXEC) && (op_q == OP_LOAD || op_q == OP_STORE ||
			op_q == OP_BITRD || op_q == OP_BITWR);
		sub.mem_we    = (op_q == OP_STORE) || (op_q == OP_BITWR);
		sub.mem_bit   = (op_q == OP_BITRD) || (op_q == OP_BITWR);
		sub.mem_addr  = opa_q[7:0];
		sub.mem_size  = size_q;
		sub.mem_bsel  = bit_q;
		sub.mem_wdata = opb_q;
		sub.div_start = (state == ST_EXEC) && (op_q == OP_DIV);
		sub.div_a     = opa_q;
		sub.div_b     = opb_q;
	end

	// Sequencer and captured request
	always_comb begin
		next_state   = state;
		next_lat_cnt = lat_cnt;
		next_op      = op_q;
		next_opa     = opa_q;
		next_opb     = opb_q;
		next_size    = size_q;
		next_sgn     = sgn_q;
		next_bit     = bit_q;
		next_cond    = cond_q;
		next_pol     = pol_q;
		next_saved   = saved_q;
		case (state)
			ST_IDLE: begin
				if (accept) begin
					next_state   = ST_EXEC;
					next_lat_cnt = 8'h1;
					next_op      = in_op;
					next_opa     = in_a;
					next_opb     = in_b;
					next_size    = in_size;
					next_sgn     = in_sgn;
					next_bit     = in_bit;
					next_cond    = in_cond;
					next_pol     = in_pol;
					next_saved   = in_saved;
				end
			end
			ST_EXEC: begin
				if (fin_en)
					next_state = ST_DONE;
				else if (op_q == OP_DIV)
					next_state = ST_DIV;
				else
					next_state = ST_MWAIT;
			end
			// Waits are bounded by the partner's fixed answer time
			ST_MWAIT, ST_DIV: begin
				if (fin_en)
					next_state = ST_DONE;
			end
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
		if (state != ST_IDLE)
			next_lat_cnt = lat_cnt + 8'h1;
	end

	// Answer update with per-flag policy
	always_comb begin
		logic [4:0] cur;
		logic [4:0] res;
		logic [4:0] sav;
		logic [4:0] upd;
		cur          = flags;
		res          = fin_f;
		sav          = saved_q;
		upd          = cur;
		next_result  = result;
		next_rem     = rem;
		next_latency = latency;
		for (int k = 0; k < `OPFU_NFLAGS; k++) begin
			case (opfu_pol_e'(pol_q[2*k +: 2]))
				POL_CLR:     upd[k] = 1'b0;
				POL_RES:     upd[k] = res[k];
				POL_RESTORE: upd[k] = sav[k];
				default:     upd[k] = cur[k];
			endcase
		end
		next_flags = fin_en ? opfu_flags_s'(upd) : flags;
		if (fin_en) begin
			next_result  = fin_res;
			next_rem     = fin_rem;
			next_latency = lat_cnt + 8'h1;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state   <= ST_IDLE;
			lat_cnt <= 8'h0;
			op_q    <= OP_SEXT;
			opa_q   <= `OPFU_RST_WORD;
			opb_q   <= `OPFU_RST_WORD;
			size_q  <= SZ_BYTE;
			sgn_q   <= 1'b0;
			bit_q   <= 3'h0;
			cond_q  <= 4'h0;
			pol_q   <= 10'h000;
			saved_q <= `OPFU_RST_FLAGS;
			result  <= `OPFU_RST_WORD;
			rem     <= `OPFU_RST_WORD;
			flags   <= `OPFU_RST_FLAGS;
			latency <= 8'h0;
		end else begin
			state   <= next_state;
			lat_cnt <= next_lat_cnt;
			op_q    <= next_op;
			opa_q   <= next_opa;
			opb_q   <= next_opb;
			size_q  <= next_size;
			sgn_q   <= next_sgn;
			bit_q   <= next_bit;
			cond_q  <= next_cond;
			pol_q   <= next_pol;
			saved_q <= next_saved;
			result  <= next_result;
			rem     <= next_rem;
			flags   <= next_flags;
			latency <= next_latency;
		end
	end

	opfu_mem u_mem (
		.clock (clock),
		.nrst  (nrst),
		.m     (sub)
	);

	opfu_div u_div (
		.clock (clock),
		.nrst  (nrst),
		.d     (sub)
	);

	assign in_ready    = (state == ST_IDLE);
	assign out_valid   = (state == ST_DONE);
	assign out_result  = result;
	assign out_rem     = rem;
	assign out_flags   = flags;
	assign out_latency = latency;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence s_alu_accept;
		accept && (in_op inside {OP_SEXT, OP_ZEXT, OP_SATADD, OP_SATSUB, OP_SHL, OP_SHR,
			OP_SAR, OP_COND});
	endsequence
	sequence s_mem_accept;
		accept && (in_op inside {OP_LOAD, OP_STORE, OP_BITRD, OP_BITWR});
	endsequence

	a_sext_byte_fill: assert property ((state == ST_EXEC && op_q == OP_SEXT && size_q == SZ_BYTE)
		|=> result[31:8] == {24{opa_q[7]}})
		else $error("sign extension did not copy the top bit");
	a_zext_half_fill: assert property ((state == ST_EXEC && op_q == OP_ZEXT && size_q == SZ_HALF)
		|=> result[31:16] == 16'h0 && result[15:0] == opa_q[15:0])
		else $error("zero extension left upper bits set");
	a_sat_clamp_hi: assert property ((state == ST_EXEC && op_q == OP_SATADD && sat_hi)
		|=> result == `OPFU_SAT_MAX)
		else $error("positive overflow not clamped");
	a_sat_wide_pass: assert property ((state == ST_EXEC && op_q == OP_SATSUB && !sat_hi && !sat_lo)
		|=> result == $past(wide_sum[31:0]))
		else $error("in-range difference altered");
	a_load_byte_size: assert property ((fin_en && state == ST_MWAIT && op_q == OP_LOAD
		&& size_q == SZ_BYTE && !sgn_q) |=> result[31:8] == 24'h0)
		else $error("byte load returned more than a byte");
	a_bit_field_sel: assert property ((out_valid && op_q == OP_BITRD)
		|-> result[31:1] == 31'h0 && flags.z == (pol_q[7:6] == 2'h2 ? ~result[0] : flags.z))
		else $error("bit read returned more than one bit");
	a_flag_keep_z: assert property ((fin_en && pol_q[7:6] == 2'h0) |=> $stable(flags.z))
		else $error("kept zero flag changed");
	a_flag_clear_ov: assert property ((fin_en && pol_q[3:2] == 2'h1) |=> !flags.ov)
		else $error("cleared overflow flag is set");
	a_flag_restore_s: assert property ((fin_en && pol_q[5:4] == 2'h3)
		|=> flags.s == $past(saved_q.s))
		else $error("restored sign flag wrong");
	a_sar_sign_fill: assert property ((state == ST_EXEC && op_q == OP_SAR && opa_q[31])
		|=> result[31])
		else $error("arithmetic shift lost the sign");
	a_cond_always: assert property ((state == ST_EXEC && op_q == OP_COND && cond_q == 4'h5)
		|=> result == 32'h1)
		else $error("unconditional test false");
	a_alu_latency: assert property (
		s_alu_accept |-> ##2 (out_valid && out_latency == `OPFU_LAT_ALU))
		else $error("simple op answer not at its latency");
	a_mem_latency: assert property (
		s_mem_accept |-> ##3 (out_valid && out_latency == `OPFU_LAT_MEM))
		else $error("memory op answer not at its latency");
endmodule // opfu_top

// *** bench/operand_primitives_flag_update_tb.sv ***
`timescale 1ns/1ps
`include "opfu_regs.svh"
module operand_primitives_flag_update_tb import opfu_pkg::*; ;
	// Stimulus
	logic         clock = 1'b0;
	logic         nrst = 1'b0;
	logic         in_valid = 1'b0;
	opfu_op_e     in_op = OP_SEXT;
	logic [31:0]  in_a = 32'h0;
	logic [31:0]  in_b = 32'h0;
	opfu_size_e   in_size = SZ_WORD;
	logic         in_sgn = 1'b0;
	opfu_bitsel_t in_bit = 3'h0;
	opfu_cond_t   in_cond = 4'h0;
	logic [9:0]   in_pol = 10'h000;
	opfu_flags_s  in_saved = 5'h00;
	// Observed
	logic         in_ready;
	logic         out_valid;
	logic [31:0]  out_result;
	logic [31:0]  out_rem;
	opfu_flags_s  out_flags;
	logic [7:0]   out_latency;
	// Tallies and measured latency
	int           num_errors = 0;
	int           compares = 0;
	int           lat;

	opfu_top uut (.clock(clock), .nrst(nrst), .in_valid(in_valid), .in_ready(in_ready),
		.in_op(in_op), .in_a(in_a), .in_b(in_b), .in_size(in_size), .in_sgn(in_sgn),
		.in_bit(in_bit), .in_cond(in_cond), .in_pol(in_pol), .in_saved(in_saved),
		.out_valid(out_valid), .out_result(out_result), .out_rem(out_rem),
		.out_flags(out_flags), .out_latency(out_latency));

	// 100 ns period
	always #50 clock = ~clock;

	// Verdict and stop
	task end_of_test;
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Case equality, so unknowns never match
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s exp %h seen %h", name, exp, seen);
		end
	endtask

	// One request, entered at a falling edge, returns at the answer's falling edge
	task op(input opfu_op_e o, input logic [31:0] a, input logic [31:0] b,
		input opfu_size_e sz, input logic sg, input logic [2:0] bt, input logic [9:0] pol);
		int n;
		n = 0;
		while (in_ready !== 1'b1) begin
			@(negedge clock);
			n++;
			if (n > 50) begin
				num_errors++;
				end_of_test;
			end
		end
		in_op = o;
		in_a = a;
		in_b = b;
		in_size = sz;
		in_sgn = sg;
		in_bit = bt;
		in_pol = pol;
		in_valid = 1'b1;
		@(negedge clock);
		in_valid = 1'b0;
		lat = 1;
		// Bounded wait; DIV is the longest at 35
		while (out_valid !== 1'b1) begin
			@(negedge clock);
			lat++;
			if (lat > 60) begin
				num_errors++;
				end_of_test;
			end
		end
		chk("latency", {24'h0, out_latency}, lat);
	endtask

	// Widening by sign and by zeros
	task t_ext;
		op(OP_SEXT, 32'h12345680, 32'h0, SZ_BYTE, 1'b0, 3'h0, 10'h000);
		chk("sext byte", out_result, 32'hffffff80);
		chk("alu latency", lat, `OPFU_LAT_ALU);
		op(OP_SEXT, 32'h0001807f, 32'h0, SZ_BYTE, 1'b0, 3'h0, 10'h000);
		chk("sext byte pos", out_result, 32'h0000007f);
		op(OP_SEXT, 32'h00018000, 32'h0, SZ_HALF, 1'b0, 3'h0, 10'h000);
		chk("sext half", out_result, 32'hffff8000);
		op(OP_ZEXT, 32'h12345680, 32'h0, SZ_BYTE, 1'b0, 3'h0, 10'h000);
		chk("zext byte", out_result, 32'h00000080);
		op(OP_ZEXT, 32'hffff8000, 32'h0, SZ_HALF, 1'b0, 3'h0, 10'h000);
		chk("zext half", out_result, 32'h00008000);
		$display("test ext done");
	endtask

	// Clamping at both ends of the signed range
	task t_sat;
		op(OP_SATADD, 32'h7fffffff, 32'h1, SZ_WORD, 1'b0, 3'h0, 10'h000);
		chk("satadd hi", out_result, `OPFU_SAT_MAX);
		op(OP_SATADD, 32'h80000000, 32'hffffffff, SZ_WORD, 1'b0, 3'h0, 10'h000);
		chk("satadd lo", out_result, `OPFU_SAT_MIN);
		op(OP_SATSUB, 32'h80000000, 32'h1, SZ_WORD, 1'b0, 3'h0, 10'h000);
		chk("satsub lo", out_result, `OPFU_SAT_MIN);
		op(OP_SATSUB, 32'h00000005, 32'h3, SZ_WORD, 1'b0, 3'h0, 10'h000);
		chk("satsub mid", out_result, 32'h00000002);
		$display("test sat done");
	endtask

	// Sized stores and loads; memory is unset until written
	task t_mem;
		op(OP_STORE, 32'h10, 32'h11223344, SZ_WORD, 1'b0, 3'h0, 10'h000);
		chk("mem latency", lat, `OPFU_LAT_MEM);
		op(OP_STORE, 32'h12, 32'hffffff80, SZ_BYTE, 1'b0, 3'h0, 10'h000);
		op(OP_LOAD, 32'h10, 32'h0, SZ_WORD, 1'b0, 3'h0, 10'h000);
		chk("byte store", out_result, 32'h11803344);
		op(OP_LOAD, 32'h11, 32'h0, SZ_BYTE, 1'b0, 3'h0, 10'h000);
		chk("load byte", out_result, 32'h00000033);
		op(OP_LOAD, 32'h12, 32'h0, SZ_BYTE, 1'b1, 3'h0, 10'h000);
		chk("load sbyte", out_result, 32'hffffff80);
		op(OP_LOAD, 32'h12, 32'h0, SZ_HALF, 1'b0, 3'h0, 10'h000);
		chk("load half", out_result, 32'h00001180);
		$display("test mem done");
	endtask

	// Bit read through the zero flag, bit write of one position only
	task t_bit;
		op(OP_BITRD, 32'h10, 32'h0, SZ_BYTE, 1'b0, 3'h2, 10'h080);
		chk("bitrd set", out_flags.z, 1'b0);
		op(OP_BITRD, 32'h10, 32'h0, SZ_BYTE, 1'b0, 3'h3, 10'h080);
		chk("bitrd clear", out_flags.z, 1'b1);
		op(OP_BITWR, 32'h10, 32'h1, SZ_BYTE, 1'b0, 3'h0, 10'h000);
		op(OP_BITWR, 32'h10, 32'h0, SZ_BYTE, 1'b0, 3'h6, 10'h000);
		op(OP_LOAD, 32'h10, 32'h0, SZ_WORD, 1'b0, 3'h0, 10'h000);
		chk("bitwr word", out_result, 32'h11803305);
		$display("test bit done");
	endtask

	// Zero fill versus sign fill
	task t_shift;
		op(OP_SHL, 32'h80000001, 32'h1, SZ_WORD, 1'b0, 3'h0, 10'h000);
		chk("shl", out_result, 32'h00000002);
		op(OP_SHR, 32'h80000000, 32'h4, SZ_WORD, 1'b0, 3'h0, 10'h000);
		chk("shr", out_result, 32'h08000000);
		op(OP_SAR, 32'h80000000, 32'h4, SZ_WORD, 1'b0, 3'h0, 10'h000);
		chk("sar", out_result, 32'hf8000000);
		$display("test shift done");
	endtask

	// Quotient and separate remainder, divisor zero too
	task t_div;
		op(OP_DIV, 32'd100, 32'd7, SZ_WORD, 1'b0, 3'h0, 10'h000);
		chk("quotient", out_result, 32'd14);
		chk("remainder", out_rem, 32'd2);
		chk("div latency", lat, 35);
		op(OP_DIV, 32'd9, 32'd0, SZ_WORD, 1'b0, 3'h0, 10'h000);
		chk("div0 quo", out_result, 32'hffffffff);
		chk("div0 rem", out_rem, 32'd9);
		$display("test div done");
	endtask

	// Restore, clear, keep, from result; then condition codes
	task t_flags;
		logic [5:0] exp;
		logic [3:0] cc [6];
		exp = 6'b101101;
		cc = '{4'h0, 4'h8, 4'h5, 4'hd, 4'h2, 4'ha};
		in_saved = 5'h15;
		op(OP_SATADD, 32'h1, 32'h1, SZ_WORD, 1'b0, 3'h0, 10'h3ff);
		chk("restore", out_flags, 5'h15);
		op(OP_SATADD, 32'h7fffffff, 32'h1, SZ_WORD, 1'b0, 3'h0, 10'h155);
		chk("clear", out_flags, 5'h00);
		op(OP_SATADD, 32'h7fffffff, 32'h1, SZ_WORD, 1'b0, 3'h0, 10'h000);
		chk("keep", out_flags, 5'h00);
		op(OP_SATADD, 32'h7fffffff, 32'h1, SZ_WORD, 1'b0, 3'h0, 10'h2aa);
		chk("from result", {out_flags.sat, out_flags.ov, out_flags.z}, 3'h6);
		for (int k = 0; k < 6; k++) begin
			in_cond = cc[k];
			op(OP_COND, 32'h0, 32'h0, SZ_WORD, 1'b0, 3'h0, 10'h000);
			chk("cond", out_result, {31'h0, exp[5 - k]});
		end
		$display("test flags done");
	endtask

	// Main sequence
	initial begin
		repeat (3) @(negedge clock);
		chk("rst ready", in_ready, 1'b1);
		chk("rst valid", out_valid, 1'b0);
		chk("rst result", out_result, `OPFU_RST_WORD);
		nrst = 1'b1;
		t_ext;
		t_sat;
		t_mem;
		t_bit;
		t_shift;
		t_div;
		t_flags;
		end_of_test;
	end
endmodule // operand_primitives_flag_update_tb
